/* File: rtl/trigger_ctrl_reg_pkg.sv */
// Constants, register map and state carriers of the converter control block
package trigger_ctrl_reg_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the processor bus
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_RESULT_CH0_HI = 4'h0;
	localparam logic [3:0] OFS_RESULT_CH0_LO = 4'h1;
	localparam logic [3:0] OFS_RESULT_CH1_HI = 4'h2;
	localparam logic [3:0] OFS_RESULT_CH1_LO = 4'h3;
	localparam logic [3:0] OFS_RESULT_CH2_HI = 4'h4;
	localparam logic [3:0] OFS_RESULT_CH2_LO = 4'h5;
	localparam logic [3:0] OFS_RESULT_CH3_HI = 4'h6;
	localparam logic [3:0] OFS_RESULT_CH3_LO = 4'h7;
	localparam logic [3:0] OFS_CTRL_STATUS = 4'h8;
	localparam logic [3:0] OFS_TRIGGER_CTRL = 4'h9;
	localparam logic [7:0] UNMAPPED_READ = 8'hff;

	// ----------------------------------------------------------------
	// Control/status and trigger control fields
	// ----------------------------------------------------------------
	localparam int BIT_DONE_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_START = 5;
	localparam int BIT_SCAN = 4;
	localparam int BIT_TIME_SEL = 3;
	localparam int BIT_TRIG_ENABLE = 7;
	localparam logic [5:0] TRIG_RSVD_ONES = 6'h3f;

	// ----------------------------------------------------------------
	// Result layout and reset values
	// ----------------------------------------------------------------
	localparam int NUM_CHANNELS = 4;
	localparam int RESULT_BITS = 10;
	localparam int RESULT_LSB = 6;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [7:0] TEMP_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Conversion times in states; one state is one clock period
	// ----------------------------------------------------------------
	localparam int STATE_NS = 50;
	localparam int CLOCK_NS = 50;
	localparam int FIRST_SLOW_STATES = 134;
	localparam int FIRST_FAST_STATES = 70;
	localparam int NEXT_SLOW_STATES = 128;
	localparam int NEXT_FAST_STATES = 66;
	localparam int TIME_W = 8;
	localparam logic [TIME_W-1:0] FIRST_SLOW_CYC =
		TIME_W'((FIRST_SLOW_STATES * STATE_NS) / CLOCK_NS);
	localparam logic [TIME_W-1:0] FIRST_FAST_CYC =
		TIME_W'((FIRST_FAST_STATES * STATE_NS) / CLOCK_NS);
	localparam logic [TIME_W-1:0] NEXT_SLOW_CYC =
		TIME_W'((NEXT_SLOW_STATES * STATE_NS + CLOCK_NS - 1) / CLOCK_NS);
	localparam logic [TIME_W-1:0] NEXT_FAST_CYC =
		TIME_W'((NEXT_FAST_STATES * STATE_NS + CLOCK_NS - 1) / CLOCK_NS);

	// ----------------------------------------------------------------
	// State carriers
	// ----------------------------------------------------------------
	typedef enum logic {SEQ_IDLE, SEQ_RUN} trigger_ctrl_reg_seq_e;

	typedef struct packed {
		logic done_flag;
		logic irq_enable;
		logic start;
		logic scan;
		logic time_sel;
		logic [2:0] chan_sel;
	} trigger_ctrl_reg_csr_s;

	typedef struct packed {
		logic busy;
		logic [TIME_W-1:0] count;
	} trigger_ctrl_reg_timer_s;

endpackage

/* File: rtl/trigger_ctrl_reg_conv_timer.sv */
// Conversion period timer: times one conversion and pulses at its end
`timescale 1ns/1ns
module trigger_ctrl_reg_conv_timer
	import trigger_ctrl_reg_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [TIME_W-1:0] length,
	output logic busy,
	output logic done
);

	trigger_ctrl_reg_timer_s s;
	trigger_ctrl_reg_timer_s next_s;

	// ----------------------------------------------------------------
	// Countdown; done fires length cycles after the start cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		// Done is pure state: the abort path depends on done, so no feedback
		done = s.busy && (s.count == '0);
		if (start)
		begin
			next_s.busy = 1'b1;
			next_s.count = length - TIME_W'(1);
		end
		else if (abort || done)
		begin
			next_s.busy = 1'b0;
			next_s.count = '0;
		end
		else if (s.busy)
		begin
			next_s.count = s.count - TIME_W'(1);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign busy = s.busy;

endmodule

/* File: rtl/trigger_ctrl_reg_control_result_regs.sv */
// Converter control, status and result registers behind the 8-bit processor bus
//
// Summary of operation
// - Four read-only 16-bit result registers, one per analog channel.
// - Result sits in bits 15..6; bits 5..0 always read zero.
// - High byte read directly; low byte read from a temporary latch.
// - Reading a high byte copies that register's low byte into the latch.
// - Reset clears every result register to zero.
// - Channels 0..3 write result registers ch0..ch3 respectively.
// - Done flag sets at single conversion end or scan group end.
// - Done flag clears only by writing 0 after reading 1; resets 0.
// - Interrupt enable set: done flag raises the interrupt request.
// - Writing start begins conversion; single mode clears start at end.
// - Scan keeps converting until start cleared by software, reset, standby.
// - Mode bit: 0 single, 1 scan; resets to 0.
// - Time select: 134 states max when 0, 70 states when 1.
// - Single mode: low two channel bits pick channel 0 to 3.
// - Scan mode: group is channel 0 up to encoded channel; bit 2 ignored.
// - External trigger pin can start conversion besides software.
// - With trigger enabled, a falling edge on the pin sets start.
// - Scan restarts at group's first channel after setting the flag.
// - Later scan conversions take 128 states slow, 66 states fast.
`timescale 1ns/1ns
module trigger_ctrl_reg_control_result_regs
	import trigger_ctrl_reg_pkg::*;
#(
	parameter int CHANNELS = NUM_CHANNELS,
	parameter int DATA_BITS = RESULT_BITS
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic standby,
	input wire logic ext_convert_trigger_n,
	input wire logic [DATA_BITS-1:0] conv_value,
	output logic [1:0] conv_channel,
	output logic conv_sample,
	output logic conv_busy,
	output logic conversion_done_irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		trigger_ctrl_reg_csr_s csr;
		logic ext_trigger_enable;
		logic trig_rsvd0;
		logic flag_read_armed;
		trigger_ctrl_reg_seq_e seq;
		logic first;
		logic [1:0] chan;
		logic [CHANNELS-1:0][15:0] result;
		logic [7:0] temp_lo;
		logic [7:0] rdata;
		logic trg_s1;
		logic trg_s2;
		logic trg_s3;
	} trigger_ctrl_reg_state_s;

	trigger_ctrl_reg_state_s s;
	trigger_ctrl_reg_state_s next_s;

	logic timer_start;
	logic timer_abort;
	logic [TIME_W-1:0] timer_len;
	logic timer_busy;
	logic timer_done;
	logic trig_fall;
	logic [1:0] last_chan;
	logic [7:0] csr_byte;
	logic [7:0] trig_byte;
	logic start_rise;
	logic [15:0] new_result;

	// ----------------------------------------------------------------
	// Conversion timer
	// ----------------------------------------------------------------
	trigger_ctrl_reg_conv_timer u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.start(timer_start),
		.abort(timer_abort),
		.length(timer_len),
		.busy(timer_busy),
		.done(timer_done)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		timer_start = 1'b0;
		timer_abort = 1'b0;
		timer_len = FIRST_SLOW_CYC;
		start_rise = 1'b0;
		new_result = RESULT_RESET;
		csr_byte = s.csr;
		trig_byte = {s.ext_trigger_enable, TRIG_RSVD_ONES, s.trig_rsvd0};

		// Pin passes two flops; the edge is taken between the second and third
		next_s.trg_s1 = ext_convert_trigger_n;
		next_s.trg_s2 = s.trg_s1;
		next_s.trg_s3 = s.trg_s2;
		trig_fall = s.ext_trigger_enable && s.trg_s3 && !s.trg_s2;

		// Scan group runs from channel 0 up to the encoded one
		last_chan = s.csr.chan_sel[1:0];

		// ------------------------------------------------------------
		// Bus reads: data is registered, valid the cycle after bus_rd
		// ------------------------------------------------------------
		if (bus_rd)
		begin
			next_s.rdata = UNMAPPED_READ;
			case (bus_addr)
				OFS_RESULT_CH0_HI, OFS_RESULT_CH1_HI,
				OFS_RESULT_CH2_HI, OFS_RESULT_CH3_HI:
				begin
					next_s.rdata = s.result[bus_addr[2:1]][15:8];
					next_s.temp_lo = s.result[bus_addr[2:1]][7:0];
				end
				OFS_RESULT_CH0_LO, OFS_RESULT_CH1_LO,
				OFS_RESULT_CH2_LO, OFS_RESULT_CH3_LO:
				begin
					// Stale unless the high byte was read first
					next_s.rdata = s.temp_lo;
				end
				OFS_CTRL_STATUS:
				begin
					next_s.rdata = csr_byte;
					if (s.csr.done_flag)
					begin
						next_s.flag_read_armed = 1'b1;
					end
				end
				OFS_TRIGGER_CTRL:
				begin
					next_s.rdata = trig_byte;
				end
				default:
				begin
					next_s.rdata = UNMAPPED_READ;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Bus writes; result registers ignore writes
		// ------------------------------------------------------------
		if (bus_wr)
		begin
			case (bus_addr)
				OFS_CTRL_STATUS:
				begin
					if (s.flag_read_armed && !bus_wdata[BIT_DONE_FLAG])
					begin
						next_s.csr.done_flag = 1'b0;
					end
					next_s.flag_read_armed = 1'b0;
					next_s.csr.irq_enable = bus_wdata[BIT_IRQ_ENABLE];
					next_s.csr.start = bus_wdata[BIT_START];
					next_s.csr.scan = bus_wdata[BIT_SCAN];
					next_s.csr.time_sel = bus_wdata[BIT_TIME_SEL];
					next_s.csr.chan_sel = bus_wdata[2:0];
				end
				OFS_TRIGGER_CTRL:
				begin
					next_s.ext_trigger_enable = bus_wdata[BIT_TRIG_ENABLE];
					next_s.trig_rsvd0 = bus_wdata[0];
				end
				default:
				begin
				end
			endcase
		end

		// The trigger edge sets start just as a software write would
		if (trig_fall)
		begin
			next_s.csr.start = 1'b1;
		end

		// Standby stops a scan in progress
		if (standby)
		begin
			next_s.csr.start = 1'b0;
		end

		// ------------------------------------------------------------
		// End of one channel's conversion
		// ------------------------------------------------------------
		if (timer_done && s.seq == SEQ_RUN)
		begin
			new_result = {conv_value, RESULT_LSB'(0)};
			next_s.result[s.chan] = new_result;
			next_s.first = 1'b0;
			if (!s.csr.scan)
			begin
				// Set wins over a clear landing in the same cycle
				next_s.csr.done_flag = 1'b1;
				next_s.csr.start = 1'b0;
				next_s.seq = SEQ_IDLE;
			end
			else
			begin
				if (s.chan >= last_chan)
				begin
					next_s.csr.done_flag = 1'b1;
					next_s.chan = 2'h0;
				end
				else
				begin
					next_s.chan = s.chan + 2'h1;
				end
				if (next_s.csr.start)
				begin
					timer_start = 1'b1;
					timer_len = s.csr.time_sel ? NEXT_FAST_CYC : NEXT_SLOW_CYC;
				end
			end
		end

		// ------------------------------------------------------------
		// Start and stop of a conversion run
		// ------------------------------------------------------------
		start_rise = next_s.csr.start && s.seq == SEQ_IDLE;
		if (start_rise)
		begin
			next_s.seq = SEQ_RUN;
			next_s.first = 1'b1;
			next_s.chan = next_s.csr.scan ? 2'h0 : next_s.csr.chan_sel[1:0];
			timer_start = 1'b1;
			timer_len = next_s.csr.time_sel ? FIRST_FAST_CYC : FIRST_SLOW_CYC;
		end
		else if (!next_s.csr.start && s.seq == SEQ_RUN)
		begin
			// A cleared start bit drops the running conversion unwritten
			timer_start = 1'b0;
			timer_abort = 1'b1;
			next_s.seq = SEQ_IDLE;
			next_s.first = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.seq <= SEQ_IDLE;
			s.temp_lo <= TEMP_RESET;
			s.rdata <= TEMP_RESET;
			s.trg_s1 <= 1'b1;
			s.trg_s2 <= 1'b1;
			s.trg_s3 <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rdata = s.rdata;
	assign conv_channel = s.chan;
	assign conv_sample = timer_start;
	assign conv_busy = timer_busy;
	assign conversion_done_irq = s.csr.done_flag && s.csr.irq_enable;

endmodule

/* File: tb/trigger_ctrl_reg_props.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ns
module trigger_ctrl_reg_props
	import trigger_ctrl_reg_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [7:0] bus_rdata,
	input wire logic standby,
	input wire logic [1:0] conv_channel,
	input wire logic conv_sample,
	input wire logic conv_busy,
	input wire logic conversion_done_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	int busy_cnt;
	// ----
	// Cycles since the last sample pulse
	// ----
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			busy_cnt <= 0;
		else
			busy_cnt <= conv_sample ? 0 : busy_cnt + 1;
	sequence s_standby_held;
		standby [*3];
	endsequence
	AST_SAMPLE_BUSY: assert property (conv_sample |=> conv_busy)
		else $error("sample pulse not followed by busy");
	AST_TIME: assert property (conv_busy |-> busy_cnt < FIRST_SLOW_STATES)
		else $error("conversion longer than slow time");
	AST_IRQ_RISE: assert property ($rose(conversion_done_irq) |-> $past(conv_busy) || $past(bus_wr))
		else $error("irq rose without conversion end or write");
	AST_IRQ_HOLD: assert property (conversion_done_irq && !bus_wr |=> conversion_done_irq)
		else $error("irq dropped without a write");
	AST_RDATA_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data changed without a read");
	AST_LO_ZERO: assert property (bus_rd && bus_addr[0] && !bus_addr[3] |=> bus_rdata[5:0] == 6'h00)
		else $error("low result bits not zero");
	AST_CHAN: assert property (conv_busy && $changed(conv_channel) |-> $past(conv_sample))
		else $error("channel changed inside a conversion");
	AST_STANDBY: assert property (s_standby_held |-> !conv_busy)
		else $error("busy during standby");
endmodule

/* File: tb/trigger_ctrl_reg_analog_src.sv */
// Analog source model: one held level per input channel
`timescale 1ns/1ns
module trigger_ctrl_reg_analog_src
	import trigger_ctrl_reg_pkg::*;
(
	input wire logic [1:0] conv_channel,
	output logic [RESULT_BITS-1:0] conv_value
);
	logic [RESULT_BITS-1:0] level [NUM_CHANNELS];
	// Levels are held steady by the bench across each conversion
	assign conv_value = level[conv_channel];
endmodule

/* File: tb/trigger_ctrl_reg_control_result_regs_tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module trigger_ctrl_reg_control_result_regs_tb_top
	import trigger_ctrl_reg_pkg::*;
;
	logic clock = 0, rst_n = 0, bus_rd = 0, bus_wr = 0, standby = 0, trig_n = 1;
	logic [3:0] bus_addr = 4'h0;
	logic [7:0] bus_wdata = 8'h00, bus_rdata, cs;
	logic [9:0] conv_value;
	logic [1:0] conv_channel, ch;
	logic conv_sample, conv_busy, irq, ts;
	int fail_count = 0, checked = 0, cycles = 0, n;
	logic [15:0] exp_res [4];
	always #25 clock = ~clock;
	trigger_ctrl_reg_control_result_regs DUT (.clock, .rst_n, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
		.bus_rdata, .standby, .ext_convert_trigger_n(trig_n), .conv_value, .conv_channel,
		.conv_sample, .conv_busy, .conversion_done_irq(irq));
	trigger_ctrl_reg_analog_src SRC (.conv_channel, .conv_value);
	// ----
	// Checks and bus cycles
	// ----
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_count(input string what, input int exp, input int got);
		checked++;
		if (got != exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1;
		@(negedge clock);
		bus_wr = 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(negedge clock);
		bus_addr = a;
		bus_rd = 1;
		@(negedge clock);
		bus_rd = 0;
		chk_byte(what, exp, bus_rdata);
	endtask
	task automatic chk_result(input int c);
		rd(4'(2 * c), exp_res[c][15:8], "result hi");
		rd(4'(2 * c + 1), exp_res[c][7:0], "result lo");
	endtask
	task automatic set_level(input int c);
		SRC.level[c] = 10'($urandom);
		exp_res[c] = {SRC.level[c], 6'h00};
	endtask
	task automatic wait_irq(input int limit);
		n = 0;
		while (irq !== 1'b1 && n < limit)
		begin
			@(negedge clock);
			n++;
		end
	endtask
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			conclude;
		end
	end
	// ----
	// Scenarios
	// ----
	initial
	begin
		void'($urandom(79541));
		repeat (3) @(negedge clock);
		rst_n = 1;
		for (int a = 0; a < 8; a++)
			rd(4'(a), 8'h00, "result reset");
		rd(OFS_CTRL_STATUS, 8'h00, "csr reset");
		rd(OFS_TRIGGER_CTRL, 8'h7e, "trigger reset");
		rd(4'hc, UNMAPPED_READ, "unmapped");
		wr(OFS_RESULT_CH0_HI, 8'hff);
		rd(OFS_RESULT_CH0_HI, 8'h00, "ro result");
		for (int i = 0; i < 8; i++)
		begin
			ch = 2'(i);
			ts = i[2];
			set_level(i % 4);
			cs = {4'h4, ts, 1'($urandom), ch};
			wr(OFS_CTRL_STATUS, cs | 8'h20);
			wait_irq(200);
			chk_count("single time", ts ? FIRST_FAST_STATES : FIRST_SLOW_STATES, n);
			chk_result(i % 4);
			wr(OFS_CTRL_STATUS, 8'h80 | cs[3:0]);
			chk_byte("irq masked", 8'h00, {7'h0, irq});
			wr(OFS_CTRL_STATUS, cs);
			chk_byte("flag kept", 8'h01, {7'h0, irq});
			rd(OFS_CTRL_STATUS, 8'h80 | cs, "single csr");
			wr(OFS_CTRL_STATUS, cs);
			chk_byte("flag cleared", 8'h00, {7'h0, irq});
		end
		for (int k = 0; k < 4; k++)
			chk_result(k);
		for (int k = 0; k < 4; k++)
			set_level(k);
		// Channel field top bit set: it must not widen the group
		wr(OFS_CTRL_STATUS, 8'h7f);
		wait_irq(400);
		chk_count("scan time", FIRST_FAST_STATES + 3 * NEXT_FAST_STATES, n);
		chk_byte("scan restart", 8'h01, {7'h0, conv_busy});
		rd(OFS_CTRL_STATUS, 8'hff, "scan csr");
		wr(OFS_CTRL_STATUS, 8'h5f);
		@(negedge clock);
		chk_byte("scan stop", 8'h00, {7'h0, conv_busy});
		for (int k = 0; k < 4; k++)
			chk_result(k);
		wr(OFS_CTRL_STATUS, 8'h78);
		repeat (10) @(negedge clock);
		standby = 1;
		repeat (3) @(negedge clock);
		rd(OFS_CTRL_STATUS, 8'h58, "standby csr");
		chk_byte("standby busy", 8'h00, {7'h0, conv_busy});
		standby = 0;
		for (int k = 0; k < 2; k++)
			set_level(k);
		// Slow scan over channels 0 and 1
		wr(OFS_CTRL_STATUS, 8'h71);
		wait_irq(400);
		chk_count("slow scan time", FIRST_SLOW_STATES + NEXT_SLOW_STATES, n);
		chk_byte("slow scan channel", 8'h00, {6'h00, conv_channel});
		rd(OFS_CTRL_STATUS, 8'hf1, "slow scan csr");
		wr(OFS_CTRL_STATUS, 8'h51);
		for (int k = 0; k < 2; k++)
			chk_result(k);
		set_level(2);
		wr(OFS_CTRL_STATUS, 8'h42);
		// A falling pin edge with the trigger disabled must not start
		trig_n = 0;
		repeat (5) @(negedge clock);
		trig_n = 1;
		rd(OFS_CTRL_STATUS, 8'h42, "trigger off csr");
		wr(OFS_TRIGGER_CTRL, 8'h80);
		rd(OFS_TRIGGER_CTRL, 8'hfe, "trigger ctrl");
		// Two sync flops plus the edge flop: start lands on the third edge
		trig_n = 0;
		wait_irq(300);
		trig_n = 1;
		chk_count("trigger time", FIRST_SLOW_STATES + 3, n);
		chk_byte("trigger irq", 8'h01, {7'h0, irq});
		chk_result(2);
		conclude;
	end
endmodule
bind trigger_ctrl_reg_control_result_regs trigger_ctrl_reg_props u_props (.clock, .rst_n, .bus_addr, .bus_rd, .bus_wr,
	.bus_rdata, .standby, .conv_channel, .conv_sample, .conv_busy, .conversion_done_irq);
